// ---- src/ecp_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_fifo import ecp_pkg::*; #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic flush, // Empties the queue
	input wire logic wrap, // Test behaviour: never stall
	input wire logic push, // Write one entry
	input wire logic [WIDTH-1:0] pushData, // Entry to write
	input wire logic pop, // Read one entry
	output logic [WIDTH-1:0] popData, // Entry at the head
	output logic [$clog2(DEPTH+1)-1:0] count, // Occupancy
	output logic full, // No free entry
	output logic empty, // No entry held
	output logic fault // Overrun or underrun this cycle
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wrPtr; // Next slot to write
	logic [AW-1:0] rdPtr; // Head slot
	logic wrOk, rdOk, dropOldest;

	assign full = (count == CW'(DEPTH));
	assign empty = (count == '0);
	assign popData = mem[rdPtr];
	assign wrOk = push && (!full || pop || wrap);
	assign rdOk = pop && !empty;
	// An overwrite drops the oldest entry so the count stays honest
	assign dropOldest = push && full && !pop && wrap;
	assign fault = (push && full && !pop) || (pop && empty);

	// Storage write
	always_ff @(posedge clock) begin
		if (wrOk) begin
			mem[wrPtr] <= pushData;
		end
	end

	// Pointers and occupancy
	always_ff @(posedge clock) begin
		if (srst || flush) begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
		end else begin
			if (wrOk) begin
				wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
			end
			// Underrun rereads the head without moving it
			if (rdOk || dropOldest) begin
				rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
			end
			count <= count + CW'(wrOk && !dropOldest) - CW'(rdOk);
		end
	end
endmodule
`default_nettype wire

// ---- src/ecp_mode_config_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_mode_config_regs import ecp_pkg::*; #(
	parameter int DEPTH = 16,
	parameter int WR_THRESH = 8, // Free entries that call for a refill
	parameter int RD_THRESH = 8 // Held entries that call for a drain
) (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire ecp_host_req_t hostReq, // Host I/O and DMA cycle
	output logic [7:0] rdData, // Read answer, one cycle after rd
	output logic dmaReq, // DMA request
	input wire logic [3:0] irqSelect, // Assigned IRQ number
	input wire logic [1:0] dmaSelect, // Assigned DMA channel
	input wire logic irqLineIn, // Level on the assigned IRQ line
	output logic irqOut, // Interrupt level to the host
	output logic irqOe, // Interrupt driver enable
	input wire logic [7:0] pdIn, // Data pins in
	output logic [7:0] pdOut, // Data pins out
	output logic pdOe, // Data pins drive enable
	input wire logic busy, // Peripheral busy
	input wire logic peripheralAckN, // Peripheral ack, low active
	output logic [3:0] ctrlOut, // Select-in, init, auto feed, strobe pin levels
	output logic [3:0] ctrlOe // Drive enables of the control pins
);
	localparam int CW = $clog2(DEPTH+1);
	ecp_mode_t mode; // Current mode field
	ecp_pctl_t pctl; // Port control register
	logic [7:0] dataLatch; // Data register for modes 000/001
	logic errIrqDisable; // Extended control bit 4
	logic dmaEnable; // Extended control bit 3
	logic serviceIrqFlag; // Extended control bit 2
	logic capMisc; // Capability A spare bit
	logic queueError; // Sticky overrun/underrun
	logic tcSeen; // Sticky terminal count
	logic svcPending; // Service interrupt towards host
	logic [8:0] fifoHead;
	logic [CW-1:0] fifoCount;
	logic fifoFull, fifoEmpty, fifoFault;
	logic xfPop, xfPush, xfStrobe, xfAutoFeed;
	logic [7:0] xfData;
	logic compatMode, autoMode, fifoMode, modeOk, enterCompat;
	logic ectlWr, pctlWr, fifoWr, fifoRd, dataWr, addrWr;
	logic hostPush, hostPop, fifoPush, fifoPop;
	logic [8:0] fifoIn;
	logic thresholdHit, svcEvent;
	logic [7:0] capA, capB, ectlRead;
	ecp_mode_t wrMode;

	// IRQ number to capability code
	function automatic logic [2:0] irqCode(input logic [3:0] irq);
		case (irq)
			4'h5: irqCode = 3'b111;
			4'hf: irqCode = 3'b110;
			4'he: irqCode = 3'b101;
			4'hb: irqCode = 3'b100;
			4'ha: irqCode = 3'b011;
			4'h9: irqCode = 3'b010;
			4'h7: irqCode = 3'b001;
			default: irqCode = 3'b000;
		endcase
	endfunction

	// Mode classes
	assign compatMode = (mode == MODE_STD) || (mode == MODE_BIDIR);
	assign autoMode = (mode == MODE_FIFOSTD) || (mode == MODE_ECP);
	assign fifoMode = autoMode || (mode == MODE_TEST);
	assign wrMode = ecp_mode_t'(hostReq.wrData[7:5]);
	// Leaving a non-compatible mode is only allowed back to 000/001; reserved codes never take
	assign modeOk = (compatMode || wrMode == MODE_STD || wrMode == MODE_BIDIR) &&
		(wrMode != MODE_RSV4) && (wrMode != MODE_RSV5);
	assign ectlWr = hostReq.wr && !hostReq.dmaAck && (hostReq.addr == OFS_ECTL);
	assign enterCompat = ectlWr && modeOk && (wrMode == MODE_STD || wrMode == MODE_BIDIR);
	assign pctlWr = hostReq.wr && !hostReq.dmaAck && (hostReq.addr == OFS_PCTL);
	assign dataWr = hostReq.wr && !hostReq.dmaAck && (hostReq.addr == OFS_DATA);
	assign fifoWr = hostReq.wr && (hostReq.dmaAck || hostReq.addr == OFS_FIFO);
	assign fifoRd = hostReq.rd && (hostReq.dmaAck || hostReq.addr == OFS_FIFO);

	// Host pushes: standard FIFO mode, ECP forward data/address, test mode in any direction
	// Address bytes carry a ninth bit that becomes auto feed
	assign addrWr = dataWr && (mode == MODE_ECP) && !pctl.dir;
	assign hostPush = (fifoWr && ((mode == MODE_FIFOSTD) || (mode == MODE_TEST) ||
		(mode == MODE_ECP && !pctl.dir))) || addrWr;
	assign hostPop = fifoRd && ((mode == MODE_TEST) || (mode == MODE_ECP && pctl.dir));
	// Test mode never feeds the engine, so the port is left alone
	assign fifoPush = hostPush || (xfPush && mode == MODE_ECP);
	assign fifoPop = hostPop || (xfPop && autoMode);
	// Captured byte is the engine's own sample, so byte and push line up
	assign fifoIn = xfPush ? {1'b0, xfData} : {addrWr, hostReq.wrData};

	ecp_fifo #(
		.WIDTH(9),
		.DEPTH(DEPTH)
	) u_fifo (
		.clock(clock),
		.srst(srst),
		.flush(compatMode || enterCompat),
		.wrap(mode == MODE_TEST),
		.push(fifoPush),
		.pushData(fifoIn),
		.pop(fifoPop),
		.popData(fifoHead),
		.count(fifoCount),
		.full(fifoFull),
		.empty(fifoEmpty),
		.fault(fifoFault)
	);

	ecp_xfer u_xfer (
		.clock(clock),
		.srst(srst),
		.runCompat(mode == MODE_FIFOSTD),
		.runEcp(mode == MODE_ECP),
		.reverse(pctl.dir),
		.haveByte(!fifoEmpty),
		.haveRoom(!fifoFull),
		.headByte(fifoHead),
		.pinData(pdIn),
		.busy(busy),
		.peripheralAckN(peripheralAckN),
		.popByte(xfPop),
		.pushByte(xfPush),
		.sendData(xfData),
		.strobeActive(xfStrobe),
		.autoFeedActive(xfAutoFeed)
	);

	// Forward: enough room to refill; reverse: enough bytes to drain
	assign thresholdHit = fifoMode && !dmaEnable &&
		(pctl.dir ? (fifoCount >= CW'(RD_THRESH)) : (fifoCount <= CW'(DEPTH - WR_THRESH)));
	// Level test, so the threshold fires again after each clear
	assign svcEvent = thresholdHit || (fifoFault && autoMode) ||
		(dmaEnable && hostReq.dmaAck && hostReq.dmaTc);

	// Mode field; other extended control bits are free in every mode
	always_ff @(posedge clock) begin
		if (srst) begin
			mode <= ecp_mode_t'(ECTL_RESET[7:5]);
			errIrqDisable <= ECTL_RESET[ECTL_ERRDIS];
			dmaEnable <= ECTL_RESET[ECTL_DMAEN];
		end else if (ectlWr) begin
			if (modeOk) begin
				mode <= wrMode;
			end
			// A refused mode change still takes the enable bits
			errIrqDisable <= hostReq.wrData[ECTL_ERRDIS];
			dmaEnable <= hostReq.wrData[ECTL_DMAEN];
		end
	end

	// Service flag: hardware set wins over a software clear in the same cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			serviceIrqFlag <= ECTL_RESET[ECTL_SVC];
			svcPending <= 1'b0;
		end else begin
			if (ectlWr) begin
				serviceIrqFlag <= hostReq.wrData[ECTL_SVC];
				svcPending <= 1'b0;
			end
			// An event is never lost to a write in the same cycle
			if (svcEvent && (!serviceIrqFlag || (ectlWr && !hostReq.wrData[ECTL_SVC]))) begin
				serviceIrqFlag <= 1'b1;
				svcPending <= 1'b1;
			end
		end
	end

	// Sticky error and terminal count; test mode overruns are not errors
	always_ff @(posedge clock) begin
		if (srst || compatMode) begin
			queueError <= 1'b0;
			tcSeen <= 1'b0;
		end else begin
			if (enterCompat) begin
				queueError <= 1'b0;
				tcSeen <= 1'b0;
			end else if (ectlWr && !hostReq.wrData[ECTL_DMAEN]) begin
				tcSeen <= 1'b0;
			end
			// Test mode wraps on purpose, only the engine modes flag errors
			if (fifoFault && autoMode) begin
				queueError <= 1'b1;
			end
			if (dmaEnable && hostReq.dmaAck && hostReq.dmaTc) begin
				tcSeen <= 1'b1;
			end
		end
	end

	// Port control and data latch; direction moves only in 000/001
	always_ff @(posedge clock) begin
		if (srst) begin
			pctl <= '0;
			dataLatch <= 8'h00;
		end else begin
			if (pctlWr) begin
				pctl.ackIrqEnable <= hostReq.wrData[4];
				pctl.selectIn <= hostReq.wrData[3];
				pctl.initHigh <= hostReq.wrData[2];
				pctl.autoFeed <= hostReq.wrData[1];
				pctl.strobe <= hostReq.wrData[0];
				if (compatMode) begin
					pctl.dir <= hostReq.wrData[5];
				end
			end
			if (dataWr && compatMode) begin
				dataLatch <= hostReq.wrData;
			end
		end
	end

	// Capability A spare bit
	always_ff @(posedge clock) begin
		if (srst) begin
			capMisc <= CAPA_RESET[CAPA_MISC];
		end else if (hostReq.wr && !hostReq.dmaAck && hostReq.addr == OFS_FIFO && mode == MODE_CFG) begin
			// Outside configuration mode this offset is the FIFO
			capMisc <= hostReq.wrData[CAPA_MISC];
		end
	end

	// Read views; code bits are constants and ignore writes
	assign capA = {IMPL_CODE, capMisc, CAPA_RESET[2:0]};
	assign capB = {1'b0, irqLineIn, irqCode(irqSelect), 1'b0, dmaSelect};
	// An error reads as full and empty together
	assign ectlRead = {mode, errIrqDisable, dmaEnable, serviceIrqFlag,
		fifoFull || queueError, fifoEmpty || queueError};

	// Registered read answer; unmapped or wrong-mode reads give zero
	always_ff @(posedge clock) begin
		if (srst) begin
			rdData <= 8'h00;
		end else if (hostReq.rd) begin
			if (hostPop) begin
				rdData <= fifoHead[7:0];
			// A DMA read with no FIFO behind it pops nothing
			end else if (hostReq.dmaAck) begin
				rdData <= 8'h00;
			end else if (hostReq.addr == OFS_ECTL) begin
				rdData <= ectlRead;
			end else if (hostReq.addr == OFS_FIFO && mode == MODE_CFG) begin
				rdData <= capA;
			end else if (hostReq.addr == OFS_CAPB && mode == MODE_CFG) begin
				rdData <= capB;
			end else if (hostReq.addr == OFS_PCTL) begin
				rdData <= pctl;
			end else if (hostReq.addr == OFS_DATA && compatMode) begin
				// Reverse in mode 001 returns the pins
				rdData <= (mode == MODE_BIDIR && pctl.dir) ? pdIn : dataLatch;
			end else begin
				rdData <= 8'h00;
			end
		end
	end

	// DMA request: room when filling, data when draining
	always_ff @(posedge clock) begin
		if (srst) begin
			dmaReq <= 1'b0;
		end else begin
			// Terminal count holds the request off until software acts
			dmaReq <= dmaEnable && !tcSeen && (
				(mode == MODE_FIFOSTD && !fifoFull) ||
				(mode == MODE_ECP && (pctl.dir ? !fifoEmpty : !fifoFull)) ||
				(mode == MODE_TEST && (pctl.dir ? !fifoEmpty : !fifoFull)));
		end
	end

	// Interrupt pin; configuration mode floats it so the line can be read back
	always_ff @(posedge clock) begin
		if (srst) begin
			irqOut <= 1'b0;
			irqOe <= 1'b0;
		end else begin
			// A level, not a pulse; an extended control write drops svcPending but not the ack term
			irqOut <= svcPending || (pctl.ackIrqEnable && !peripheralAckN);
			irqOe <= (mode != MODE_CFG) && (pctl.ackIrqEnable || fifoMode);
		end
	end

	// Port pins; test mode freezes them so FIFO traffic never shows
	always_ff @(posedge clock) begin
		if (srst) begin
			pdOut <= 8'h00;
			pdOe <= 1'b1;
			ctrlOut <= 4'h0;
			ctrlOe <= 4'h0;
		end else if (mode != MODE_TEST) begin
			if (compatMode) begin
				pdOut <= dataLatch;
				pdOe <= !(mode == MODE_BIDIR && pctl.dir);
				// Open collector: only ever pull low, float to release
				ctrlOut <= 4'h0;
				ctrlOe <= {pctl.selectIn, !pctl.initHigh, pctl.autoFeed, pctl.strobe};
			end else if (autoMode) begin
				pdOut <= xfData;
				// Reverse ECP leaves the data lines to the peripheral
				pdOe <= !(mode == MODE_ECP && pctl.dir);
				ctrlOut <= {!pctl.selectIn, pctl.initHigh, !xfAutoFeed, !xfStrobe};
				ctrlOe <= 4'hf;
			end
		end
	end
endmodule
`default_nettype wire

// ---- src/ecp_pkg.sv ----
// What this block does
// - Test mode: port idle, FIFO never stalls
// - Full/empty track true FIFO occupancy unless a sticky error sets both
// - Mode 110: FIFO at 400h, any direction
// - Test mode thresholds raise service interrupt flag
// - Mode 111: capability A at 400h, reset 14h
// - Capability A bits 7:4 constant 0001
// - Capability A bit 3 read/write, 2:0 reserved
// - Mode 111: read-only capability B at 401h
// - Capability B bit 6 shows live IRQ line
// - Mode 111 releases the interrupt output
// - Capability B bits 5:3 encode the IRQ
// - Capability B bits 1:0 encode DMA channel
// - Extended control at 402h, every mode, reset 01h
// - Mode 000: FIFO reset, open collector, data out
// - Mode 001: direction 1 floats data, reads pins
// - Mode 010: FIFO bytes sent with compatibility handshake
// - Mode 011: ECP send forward, capture reverse
// - 110 FIFO only, 111 capabilities, 100/101 reserved
// - Entering 010 or 011 starts automatic transfer
// - Mode changes only through 000 or 001
// - Going to 000/001 clears FIFO, error, TC
// - Port control bit 5 selects data direction
// - Service bit set by threshold, TC or error
// - Overrun or underrun in 010/011 sets both full and empty
package ecp_pkg;
	// Host side register offsets from the port base
	localparam logic [10:0] OFS_DATA = 11'h000;
	localparam logic [10:0] OFS_PCTL = 11'h002;
	localparam logic [10:0] OFS_FIFO = 11'h400;
	localparam logic [10:0] OFS_CAPB = 11'h401;
	localparam logic [10:0] OFS_ECTL = 11'h402;
	// Reset values
	localparam logic [7:0] ECTL_RESET = 8'h01;
	localparam logic [7:0] CAPA_RESET = 8'h14;
	localparam logic [3:0] IMPL_CODE = 4'h1;
	// Extended control and capability A field positions
	localparam int ECTL_ERRDIS = 4;
	localparam int ECTL_DMAEN = 3;
	localparam int ECTL_SVC = 2;
	localparam int CAPA_MISC = 3;
	// Strobe width; the handshake needs some minimum, this is a plain default
	localparam int CLK_NS = 50;
	localparam int STROBE_NS = 1000;
	localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
	typedef enum logic [2:0] {
		MODE_STD = 3'b000,
		MODE_BIDIR = 3'b001,
		MODE_FIFOSTD = 3'b010,
		MODE_ECP = 3'b011,
		MODE_RSV4 = 3'b100,
		MODE_RSV5 = 3'b101,
		MODE_TEST = 3'b110,
		MODE_CFG = 3'b111
	} ecp_mode_t;
	// One host cycle: I/O strobes and DMA acknowledge share the data path
	typedef struct packed {
		logic [10:0] addr;
		logic [7:0] wrData;
		logic wr;
		logic rd;
		logic dmaAck;
		logic dmaTc;
	} ecp_host_req_t;
	// Port control register layout
	typedef struct packed {
		logic [1:0] rsv;
		logic dir;
		logic ackIrqEnable;
		logic selectIn;
		logic initHigh;
		logic autoFeed;
		logic strobe;
	} ecp_pctl_t;
endpackage

// ---- src/ecp_xfer.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_xfer import ecp_pkg::*; (
	input wire logic clock, // System clock
	input wire logic srst, // Synchronous reset
	input wire logic runCompat, // Mode 010 engine on
	input wire logic runEcp, // Mode 011 engine on
	input wire logic reverse, // Direction bit
	input wire logic haveByte, // FIFO not empty
	input wire logic haveRoom, // FIFO not full
	input wire logic [8:0] headByte, // FIFO head, bit 8 marks address
	input wire logic [7:0] pinData, // Data pins as seen
	input wire logic busy, // Peripheral busy level
	input wire logic peripheralAckN, // Peripheral ack, low active
	output logic popByte, // Take head byte
	output logic pushByte, // Store captured byte
	output logic [7:0] sendData, // Byte for the data pins
	output logic strobeActive, // Strobe asserted
	output logic autoFeedActive // Auto feed asserted
);
	typedef enum logic [2:0] {
		XF_IDLE = 3'b000,
		XF_SETUP = 3'b001,
		XF_PULSE = 3'b010,
		XF_WAIT = 3'b011,
		XF_REV = 3'b100
	} ecp_xfer_t;
	ecp_xfer_t state; // Handshake phase
	logic [$clog2(STROBE_CYC+1)-1:0] pulseCnt; // Strobe width counter
	logic run;

	assign run = runCompat || runEcp;

	// Handshake sequencer; leaving the mode aborts with all controls negated
	always_ff @(posedge clock) begin
		popByte <= 1'b0;
		pushByte <= 1'b0;
		if (srst || !run) begin
			state <= XF_IDLE;
			strobeActive <= 1'b0;
			autoFeedActive <= 1'b0;
			pulseCnt <= '0;
			sendData <= 8'h00;
		end else begin
			case (state)
				XF_IDLE: begin
					if (runEcp && reverse) begin
						// Peripheral offers a byte once it asserts ack
						if (haveRoom && !peripheralAckN) begin
							pushByte <= 1'b1;
							sendData <= pinData;
							autoFeedActive <= 1'b1;
							state <= XF_REV;
						end
					end else if (haveByte && !busy) begin
						sendData <= headByte[7:0];
						autoFeedActive <= runEcp && headByte[8];
						popByte <= 1'b1;
						state <= XF_SETUP;
					end
				end
				XF_SETUP: begin
					strobeActive <= 1'b1;
					pulseCnt <= '0;
					state <= XF_PULSE;
				end
				XF_PULSE: begin
					pulseCnt <= pulseCnt + 1'b1;
					// ECP waits for busy, compatibility times the strobe
					if (runEcp ? busy : (pulseCnt == ($bits(pulseCnt))'(STROBE_CYC - 1))) begin
						strobeActive <= 1'b0;
						state <= XF_WAIT;
					end
				end
				XF_WAIT: begin
					if (!busy) begin
						autoFeedActive <= 1'b0;
						state <= XF_IDLE;
					end
				end
				XF_REV: begin
					if (peripheralAckN) begin
						autoFeedActive <= 1'b0;
						state <= XF_IDLE;
					end
				end
				default: begin
					state <= XF_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb/ecp_mode_config_regs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_mode_config_regs_chk import ecp_pkg::*; #(
	parameter int DEPTH = 16 // FIFO depth
) (
	input wire logic clock, // System clock
	input wire logic srst, // Reset
	input wire ecp_host_req_t hostReq, // Host cycle
	input wire logic [7:0] rdData, // Read answer
	input wire logic dmaReq, // DMA request
	input wire logic [3:0] irqSelect, // IRQ number
	input wire logic [1:0] dmaSelect, // DMA channel
	input wire logic irqLineIn, // IRQ line level
	input wire logic irqOe, // IRQ drive enable
	input wire logic [7:0] pdOut, // Data pins out
	input wire logic pdOe, // Data drive enable
	input wire logic [3:0] ctrlOut // Control pin levels
);
	logic [2:0] modeM; // Mode as legal writes leave it
	logic dirM; // Direction as legal writes leave it
	int cnt; // Test FIFO occupancy
	logic [2:0] irqCode; // Expected IRQ field
	logic ectlWr; // Write to extended control
	logic fifoWr; // Push into FIFO
	logic fifoRd; // Pop from FIFO
	assign ectlWr = hostReq.wr && !hostReq.dmaAck && hostReq.addr == OFS_ECTL;
	assign fifoWr = hostReq.wr && (hostReq.dmaAck || hostReq.addr == OFS_FIFO);
	assign fifoRd = hostReq.rd && (hostReq.dmaAck || hostReq.addr == OFS_FIFO);
	// IRQ number to field code; unlisted numbers give zero
	always_comb begin
		case (irqSelect)
			4'h5: irqCode = 3'h7;
			4'hf: irqCode = 3'h6;
			4'he: irqCode = 3'h5;
			4'hb: irqCode = 3'h4;
			4'ha: irqCode = 3'h3;
			4'h9: irqCode = 3'h2;
			4'h7: irqCode = 3'h1;
			default: irqCode = 3'h0;
		endcase
	end
	// Only moves through 000/001 are taken, reserved codes never
	always_ff @(posedge clock) begin
		if (srst) begin
			modeM <= 3'h0;
		end else if (ectlWr && (modeM <= 3'h1 || hostReq.wrData[7:5] <= 3'h1) && hostReq.wrData[7:6] != 2'b10) begin
			modeM <= hostReq.wrData[7:5];
		end
	end
	// Direction only changes in 000/001
	always_ff @(posedge clock) begin
		if (srst) begin
			dirM <= 1'b0;
		end else if (hostReq.wr && !hostReq.dmaAck && hostReq.addr == OFS_PCTL && modeM <= 3'h1) begin
			dirM <= hostReq.wrData[5];
		end
	end
	// Saturating count: test FIFO never stalls
	always_ff @(posedge clock) begin
		if (srst || modeM <= 3'h1) begin
			cnt <= 0;
		end else if (modeM == 3'h6 && fifoWr && !fifoRd) begin
			cnt <= (cnt == DEPTH) ? DEPTH : cnt + 1;
		end else if (modeM == 3'h6 && fifoRd && !fifoWr) begin
			cnt <= (cnt == 0) ? 0 : cnt - 1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	sequence inMode(logic [2:0] m);
		modeM == m [*3];
	endsequence
	sequence rdAt(logic [10:0] a);
		hostReq.rd && !hostReq.dmaAck && hostReq.addr == a;
	endsequence
	reset_outputs_a: assert property (@(posedge clock) disable iff (1'b0) srst |=> rdData == 8'h00 && !irqOe && pdOe && !dmaReq)
		else $error("outputs wrong after reset");
	capa_fixed_a: assert property (rdAt(OFS_FIFO) ##0 modeM == 3'h7 |=> rdData[7:4] == IMPL_CODE)
		else $error("capability A code wrong");
	capb_fixed_a: assert property (rdAt(OFS_CAPB) ##0 modeM == 3'h7 |=> !rdData[7] && !rdData[2] && rdData[1:0] == $past(dmaSelect))
		else $error("capability B fixed bits or DMA wrong");
	capb_irq_a: assert property (rdAt(OFS_CAPB) ##0 modeM == 3'h7 |=> rdData[6:3] == {$past(irqLineIn), $past(irqCode)})
		else $error("capability B IRQ fields wrong");
	ectl_mode_a: assert property (rdAt(OFS_ECTL) |=> rdData[7:5] == $past(modeM))
		else $error("mode field wrong");
	ectl_flags_a: assert property (rdAt(OFS_ECTL) ##0 modeM inside {3'h0, 3'h1, 3'h6} ##0 modeM == $past(modeM)
		|=> rdData[1:0] == {$past(cnt) == DEPTH, $past(cnt) == 0})
		else $error("FIFO flags wrong");
	test_frozen_a: assert property (inMode(3'h6) |-> $stable(pdOut) && $stable(ctrlOut))
		else $error("pins moved in test mode");
	cfg_release_a: assert property (inMode(3'h7) |-> !irqOe)
		else $error("IRQ driven in configuration mode");
	std_drive_a: assert property (inMode(3'h0) |-> pdOe && !dmaReq)
		else $error("standard mode data not driven");
	bidir_float_a: assert property (inMode(3'h1) ##0 dirM && $past(dirM) |-> !pdOe)
		else $error("data driven in reverse");
endmodule
bind ecp_mode_config_regs ecp_mode_config_regs_chk #(.DEPTH(DEPTH)) i_chk (.clock(clock), .srst(srst), .hostReq(hostReq),
	.rdData(rdData), .dmaReq(dmaReq), .irqSelect(irqSelect), .dmaSelect(dmaSelect), .irqLineIn(irqLineIn),
	.irqOe(irqOe), .pdOut(pdOut), .pdOe(pdOe), .ctrlOut(ctrlOut));
`default_nettype wire

// ---- tb/ecp_mode_config_regs_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_mode_config_regs_tb_top;
	import ecp_pkg::*;
	localparam int DEPTH = 16; // FIFO depth
	logic clock, srst; // Clock and reset
	ecp_host_req_t hostReq; // Host cycle
	logic [7:0] rdData, pdOut, pdIn, got; // Data
	logic dmaReq, irqOut, irqOe, irqExt, pdOe, busy, ackN; // Single lines
	logic [3:0] irqSelect, ctrlOut, ctrlOe; // IRQ choice, control pins
	logic [1:0] dmaSelect; // DMA choice
	logic af; // Auto feed at strobe
	logic [3:0] irqTab [8] = '{4'h5, 4'hf, 4'he, 4'hb, 4'ha, 4'h9, 4'h7, 4'h3}; // IRQs in code order
	wire logic irqLine = irqOe ? irqOut : irqExt; // Shared IRQ wire
	wire logic stbPin = ctrlOe[0] ? ctrlOut[0] : 1'b1; // Pulled up
	wire logic afPin = ctrlOe[1] ? ctrlOut[1] : 1'b1; // Pulled up
	int miscompares = 0, comparisons = 0, cycles = 0, n, len;
	ecp_mode_config_regs #(.DEPTH(DEPTH)) i_dut (.clock(clock), .srst(srst), .hostReq(hostReq), .rdData(rdData),
		.dmaReq(dmaReq), .irqSelect(irqSelect), .dmaSelect(dmaSelect), .irqLineIn(irqLine), .irqOut(irqOut),
		.irqOe(irqOe), .pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe), .busy(busy), .peripheralAckN(ackN),
		.ctrlOut(ctrlOut), .ctrlOe(ctrlOe));
	ecp_periph_model i_periph (.clock(clock), .stbPin(stbPin), .pdOut(pdOut), .pdOe(pdOe), .busy(busy),
		.peripheralAckN(ackN), .pdIn(pdIn));
	// Free running clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task close_out;
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			close_out();
		end
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One cycle write strobe, qualifiers held across the taking edge
	task wrReg(input logic [10:0] a, input logic [7:0] d);
		@(negedge clock);
		hostReq.addr = a;
		hostReq.wrData = d;
		hostReq.wr = 1'b1;
		@(negedge clock);
		hostReq.wr = 1'b0;
	endtask
	// Answer is registered at the taking edge
	task rdChk(input logic [10:0] a, input logic [7:0] exp, input string what);
		@(negedge clock);
		hostReq.addr = a;
		hostReq.rd = 1'b1;
		@(negedge clock);
		hostReq.rd = 1'b0;
		got = rdData;
		if (what != "") chk(what, exp, got);
	endtask
	// Catch a strobe, note the byte and auto feed, time its width
	task strobeWatch;
		n = 0;
		while (stbPin !== 1'b0 && n < 100) begin
			@(negedge clock);
			n++;
		end
		got = pdOut;
		af = afPin;
		len = 0;
		while (stbPin === 1'b0 && len < 200) begin
			@(negedge clock);
			len++;
		end
	endtask
	initial begin
		hostReq = '0;
		irqSelect = 4'h0;
		dmaSelect = 2'h0;
		irqExt = 1'b0;
		srst = 1'b1;
		repeat (8) @(negedge clock);
		srst = 1'b0;
		rdChk(OFS_ECTL, ECTL_RESET, "ectl reset");
		wrReg(OFS_PCTL, 8'h00);
		wrReg(OFS_ECTL, 8'he0);
		rdChk(OFS_FIFO, CAPA_RESET, "capa reset");
		wrReg(OFS_FIFO, 8'h08);
		rdChk(OFS_FIFO, 8'h1c, "capa misc set");
		wrReg(OFS_FIFO, 8'hf0);
		rdChk(OFS_FIFO, 8'h14, "capa misc clear");
		for (n = 0; n < 8; n++) begin
			irqSelect = irqTab[n];
			dmaSelect = n[1:0];
			irqExt = n[0];
			rdChk(OFS_CAPB, {1'b0, n[0], 3'(7 - n), 1'b0, n[1:0]}, "capb");
		end
		wrReg(OFS_ECTL, 8'hc0);
		rdChk(OFS_ECTL, 8'he1, "refused switch");
		wrReg(OFS_ECTL, 8'h20);
		rdChk(OFS_ECTL, 8'h21, "to bidir");
		wrReg(OFS_ECTL, 8'h80);
		rdChk(OFS_ECTL, 8'h21, "reserved mode");
		wrReg(OFS_PCTL, 8'h20);
		rdChk(OFS_DATA, 8'h3c, "pin readback");
		wrReg(OFS_ECTL, 8'h00);
		repeat (4) @(negedge clock);
		wrReg(OFS_PCTL, 8'h00);
		wrReg(OFS_ECTL, 8'hc4);
		for (n = 0; n <= DEPTH; n++) wrReg(OFS_FIFO, 8'(8'h10 + n));
		rdChk(OFS_ECTL, 8'hc6, "overwrite full");
		wrReg(OFS_ECTL, 8'hc0);
		rdChk(OFS_ECTL, 8'hc2, "full no service");
		for (n = 1; n < 8; n++) rdChk(OFS_FIFO, 8'(8'h10 + n), "fifo data");
		rdChk(OFS_ECTL, 8'hc0, "above threshold");
		rdChk(OFS_FIFO, 8'h18, "fifo data");
		rdChk(OFS_ECTL, 8'hc4, "service set");
		n = 0;
		while (irqOut !== 1'b1 && n < 4) begin
			@(negedge clock);
			n++;
		end
		chk("irq out", 8'h01, {7'h0, irqOut});
		for (n = 0; n < 9; n++) rdChk(OFS_FIFO, 8'h00, "");
		rdChk(OFS_ECTL, 8'hc5, "underrun flags");
		wrReg(OFS_ECTL, 8'hc8);
		@(negedge clock);
		chk("dma request", 8'h01, {7'h0, dmaReq});
		hostReq.dmaAck = 1'b1;
		hostReq.dmaTc = 1'b1;
		hostReq.wrData = 8'h5a;
		hostReq.wr = 1'b1;
		@(negedge clock);
		hostReq = '0;
		rdChk(OFS_FIFO, 8'h5a, "dma byte");
		rdChk(OFS_ECTL, 8'hcd, "tc service");
		chk("dma after tc", 8'h00, {7'h0, dmaReq});
		wrReg(OFS_ECTL, 8'h00);
		rdChk(OFS_ECTL, 8'h01, "back to standard");
		wrReg(OFS_ECTL, 8'h44);
		wrReg(OFS_FIFO, 8'ha5);
		strobeWatch();
		chk("compat byte", 8'ha5, got);
		chk("strobe width", 8'(STROBE_CYC), 8'(len));
		repeat (10) @(negedge clock);
		wrReg(OFS_ECTL, 8'h00);
		wrReg(OFS_ECTL, 8'h64);
		wrReg(OFS_DATA, 8'h7e);
		strobeWatch();
		chk("ecp address byte", 8'h7e, got);
		chk("address auto feed", 8'h00, {7'h0, af});
		chk("strobe seen", 8'h01, {7'h0, n < 100});
		close_out();
	end
endmodule
`default_nettype wire

// ---- tb/ecp_periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module ecp_periph_model (
	input wire logic clock, // System clock
	input wire logic stbPin, // Strobe pin level, low active
	input wire logic [7:0] pdOut, // Host data out
	input wire logic pdOe, // Host drives data
	output logic busy, // Busy to host
	output logic peripheralAckN, // Ack, never pulsed here
	output logic [7:0] pdIn // Data wire level
);
	logic [2:0] dly = 3'h0; // Strobe history
	initial busy = 1'b0;
	assign peripheralAckN = 1'b1;
	// Peripheral drives its own byte once the host lets go
	assign pdIn = pdOe ? pdOut : 8'h3c;
	// Busy follows strobe four cycles late, a slow printer
	always @(posedge clock) begin
		dly <= {dly[1:0], !stbPin};
		busy <= dly[2];
	end
endmodule
`default_nettype wire
